// ===== hdl/tcc_core.v
// Purpose: counting engine of a timer with clock select, divider and prescaler
// Assumes: clock sources and external advance arrive as pins, asynchronous
// Notes:   source clocks are sampled, so each must be slower than clock / 4
`timescale 1ns/100ps
`default_nettype none
`include "tcc_consts.vh"

module tcc_core
#(
	parameter WIDE_COUNTER      = 0,
	parameter HIGH_POWER_DOMAIN = 1,
	parameter ADVANCED          = 1
)
(
	input  wire        clock,
	input  wire        arst_n,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        mainClockIn,
	input  wire        ulpClockIn,
	input  wire        midFreqClockIn,
	input  wire        lowFreqClockIn,
	input  wire        extAdvanceIn,
	input  wire        loadCondition,
	input  wire        zeroCondition,
	output reg         zeroEvent,
	output reg         loadEvent,
	output reg         advanceEvent,
	output reg         timerIdle,
	output reg  [3:0]  truePairOutput,
	output reg  [3:0]  invertedPairOutput,
	output reg  [1:0]  internalCompareEvent
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [31:0] counterValue;
	reg  [31:0] loadValue;
	reg         counterEnable;
	reg  [1:0]  countDirectionMode;
	reg  [1:0]  afterEnableValueSelect;
	reg  [1:0]  autoReload;
	reg         advanceExternal;
	reg  [1:0]  clockSourceSelect;
	reg  [7:0]  clockDivideRatio;
	reg  [7:0]  prescaleCount;
	reg         counterClockGate;
	reg         countingDown;
	reg  [31:0] captureCompareArray [0:5];
	reg  [4:0]  pinMeta;
	reg  [4:0]  pinSync;
	reg  [4:0]  pinPrev;
	reg         awHeld;
	reg  [7:0]  awAddrHeld;
	reg         wHeld;
	reg  [31:0] wDataHeld;
	reg  [3:0]  wStrbHeld;
	reg         sourceTick;
	reg  [31:0] next_counterValue;
	reg         next_counterEnable;
	reg         next_countingDown;
	reg         next_loadEvent;
	reg  [31:0] readWord;
	reg         readHit;
	wire [31:0] counterMask;
	wire [4:0]  pinRise;
	wire        busClockTick;
	wire        extBothEdges;
	wire        ratioTick;
	wire        timerCountTick;
	wire        advance;
	wire        repeatOn;
	wire        conditionSet;
	wire        doWrite;
	wire        writeHit;
	wire [31:0] controlWord;
	wire [31:0] mergedWord;
	wire [2:0]  writeIndex;
	wire [2:0]  readIndex;
	integer     i;
	integer     j;

	assign counterMask = (WIDE_COUNTER != 0) ? `TCC_MASK_WIDE : `TCC_MASK_NARROW;

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	// pinMeta feeds only pinSync, edges are seen between pinSync and pinPrev
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinMeta <= 5'h00;
			pinSync <= 5'h00;
			pinPrev <= 5'h00;
		end
		else
		begin
			pinMeta <= {extAdvanceIn, lowFreqClockIn, midFreqClockIn, ulpClockIn, mainClockIn};
			pinSync <= pinMeta;
			pinPrev <= pinSync;
		end
	end

	assign pinRise      = pinSync & ~pinPrev;
	assign extBothEdges = pinSync[4] ^ pinPrev[4];
	assign busClockTick = (HIGH_POWER_DOMAIN != 0) ? pinRise[0] : pinRise[1];

	// ----------------------------------------------------------------
	// source select, ratio divider, prescaler
	// ----------------------------------------------------------------
	always @*
	begin
		case (clockSourceSelect)
			`TCC_SRC_BUS: sourceTick = busClockTick;
			`TCC_SRC_MID: sourceTick = pinRise[2];
			`TCC_SRC_LOW: sourceTick = pinRise[3];
			default:      sourceTick = 1'b0;
		endcase
	end

	// both stages give one-cycle enables, so the counter stays on clock
	tcc_divider ratioDivider
	(
		.clock   (clock),
		.arst_n  (arst_n),
		.run     (counterClockGate),
		.tickIn  (sourceTick),
		.divide  (clockDivideRatio),
		.tickOut (ratioTick)
	);

	tcc_divider prescaler
	(
		.clock   (clock),
		.arst_n  (arst_n),
		.run     (counterClockGate),
		.tickIn  (ratioTick),
		.divide  (prescaleCount),
		.tickOut (timerCountTick)
	);

	// gate low holds the counter still and clears both dividers
	assign advance  = counterClockGate & counterEnable &
		(advanceExternal ? extBothEdges : timerCountTick);
	assign repeatOn = autoReload[0]; // value 3 behaves as 1, no debug halt here

	// ----------------------------------------------------------------
	// counting and enable next state
	// ----------------------------------------------------------------
	always @*
	begin
		next_counterValue  = counterValue;
		next_counterEnable = counterEnable;
		next_countingDown  = countingDown;
		next_loadEvent     = 1'b0;
		if (advance)
		begin
			case (countDirectionMode)
				`TCC_MODE_DOWN:
				begin
					if (counterValue == 32'h00000000)
					begin
						next_counterValue = loadValue;
						next_loadEvent    = 1'b1;
					end
					else
						next_counterValue = counterValue - 32'h00000001;
				end
				`TCC_MODE_UPDOWN:
				begin
					if (countingDown && counterValue == 32'h00000000)
					begin
						next_countingDown = 1'b0;
						next_counterValue = 32'h00000001;
					end
					else if (countingDown)
						next_counterValue = counterValue - 32'h00000001;
					else if (counterValue >= loadValue)
					begin
						next_countingDown = 1'b1;
						next_counterValue = counterValue - 32'h00000001;
					end
					else
						next_counterValue = counterValue + 32'h00000001;
				end
				`TCC_MODE_UP:
				begin
					if (counterValue >= loadValue)
						next_counterValue = 32'h00000000;
					else
						next_counterValue = counterValue + 32'h00000001;
				end
				default:
					next_counterValue = counterValue;
			endcase
			next_counterValue = next_counterValue & counterMask;
			// one-shot ends where the period ends
			if (!repeatOn && countDirectionMode != `TCC_MODE_UP &&
				next_counterValue == 32'h00000000)
				next_counterEnable = 1'b0;
			if (!repeatOn && countDirectionMode == `TCC_MODE_UP &&
				next_counterValue == (loadValue & counterMask))
				next_counterEnable = 1'b0;
		end
		// conditions start the counter, gated off they are ignored
		if (counterClockGate && loadCondition && afterEnableValueSelect == `TCC_AFTER_ENABLE_VALUE_SELECT_LOAD)
		begin
			next_counterEnable = 1'b1;
			next_counterValue  = loadValue & counterMask;
			next_countingDown  = 1'b1;
		end
		else if (counterClockGate && zeroCondition &&
			afterEnableValueSelect == `TCC_AFTER_ENABLE_VALUE_SELECT_ZERO)
		begin
			next_counterEnable = 1'b1;
			next_counterValue  = 32'h00000000;
			next_countingDown  = 1'b0;
		end
	end

	assign conditionSet = next_counterEnable & ~counterEnable;

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	assign s_axi_awready = ~awHeld;
	assign s_axi_wready  = ~wHeld;
	assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;
	assign writeIndex    = awAddrHeld[4:2] - 3'h0; // array base is 8 words in
	assign writeHit      = (awAddrHeld[1:0] == 2'h0) && (awAddrHeld <= `TCC_OFS_CLOCK_CONTROL ||
		(awAddrHeld >= `TCC_OFS_CAPTURE_BASE && awAddrHeld <= `TCC_OFS_CAPTURE_LAST));
	assign controlWord   = {23'h000000, advanceExternal, autoReload, afterEnableValueSelect,
		1'b0, countDirectionMode, counterEnable};

	// byte lanes merged over the current readback of the target
	assign mergedWord = {
		wStrbHeld[3] ? wDataHeld[31:24] : readWordAt(awAddrHeld, 2'h3),
		wStrbHeld[2] ? wDataHeld[23:16] : readWordAt(awAddrHeld, 2'h2),
		wStrbHeld[1] ? wDataHeld[15:8]  : readWordAt(awAddrHeld, 2'h1),
		wStrbHeld[0] ? wDataHeld[7:0]   : readWordAt(awAddrHeld, 2'h0)};

	function [7:0] readWordAt;
		input [7:0] addr;
		input [1:0] lane;
		reg   [31:0] word;
		begin
			word = registerRead(addr);
			readWordAt = word[lane*8 +: 8];
		end
	endfunction

	function [31:0] registerRead;
		input [7:0] addr;
		begin
			case (addr)
				`TCC_OFS_COUNTER_CONTROL:  registerRead = controlWord;
				`TCC_OFS_COUNTER_VALUE:    registerRead = counterValue;
				`TCC_OFS_LOAD_VALUE:       registerRead = loadValue;
				`TCC_OFS_CLOCK_SOURCE_SEL: registerRead = {30'h00000000, clockSourceSelect};
				`TCC_OFS_CLOCK_DIVIDE:     registerRead = {24'h000000, clockDivideRatio};
				`TCC_OFS_PRESCALE:         registerRead = {24'h000000, prescaleCount};
				`TCC_OFS_CLOCK_CONTROL:    registerRead = {31'h00000000, counterClockGate};
				default:
				begin
					if (addr >= `TCC_OFS_CAPTURE_BASE && addr <= `TCC_OFS_CAPTURE_LAST)
						registerRead = captureCompareArray[addr[4:2]];
					else
						registerRead = `TCC_RST_WORD;
				end
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// registers: hardware next state, then bus writes on top
	// ----------------------------------------------------------------
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awHeld                 <= 1'b0;
			awAddrHeld             <= `TCC_RST_BYTE;
			wHeld                  <= 1'b0;
			wDataHeld              <= `TCC_RST_WORD;
			wStrbHeld              <= 4'h0;
			s_axi_bvalid           <= 1'b0;
			s_axi_bresp            <= `TCC_RESP_OKAY;
			counterValue           <= `TCC_RST_WORD;
			loadValue              <= `TCC_RST_WORD;
			counterEnable          <= 1'b0;
			countDirectionMode     <= `TCC_MODE_DOWN;
			afterEnableValueSelect <= `TCC_AFTER_ENABLE_VALUE_SELECT_LOAD;
			autoReload             <= 2'h0;
			advanceExternal        <= 1'b0;
			clockSourceSelect      <= `TCC_SRC_BUS;
			clockDivideRatio       <= `TCC_RST_BYTE;
			prescaleCount          <= `TCC_RST_BYTE;
			counterClockGate       <= `TCC_RST_GATE;
			countingDown           <= 1'b1;
			for (i = 0; i < 6; i = i + 1)
				captureCompareArray[i] <= `TCC_RST_WORD;
		end
		else
		begin
			if (s_axi_awvalid && !awHeld)
			begin
				awHeld     <= 1'b1;
				awAddrHeld <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld)
			begin
				wHeld     <= 1'b1;
				wDataHeld <= s_axi_wdata;
				wStrbHeld <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			counterValue  <= next_counterValue;
			counterEnable <= next_counterEnable;
			countingDown  <= next_countingDown;
			if (doWrite)
			begin
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= writeHit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
				case (awAddrHeld)
					`TCC_OFS_COUNTER_CONTROL:
					begin
						// a hardware set in the same cycle wins over a cleared bit
						counterEnable          <= mergedWord[`TCC_CTL_ENABLE_BIT] | conditionSet;
						countDirectionMode     <= mergedWord[`TCC_CTL_MODE_MSB:`TCC_CTL_MODE_LSB];
						afterEnableValueSelect <= mergedWord[`TCC_CTL_AFTER_ENABLE_VALUE_SELECT_MSB:`TCC_CTL_AFTER_ENABLE_VALUE_SELECT_LSB];
						autoReload             <= mergedWord[`TCC_CTL_REPEAT_MSB:`TCC_CTL_REPEAT_LSB];
						advanceExternal        <= mergedWord[`TCC_CTL_ADVSRC_BIT];
						if (mergedWord[`TCC_CTL_ENABLE_BIT] && !counterEnable && !conditionSet)
						begin
							case (mergedWord[`TCC_CTL_AFTER_ENABLE_VALUE_SELECT_MSB:`TCC_CTL_AFTER_ENABLE_VALUE_SELECT_LSB])
								`TCC_AFTER_ENABLE_VALUE_SELECT_LOAD:
								begin
									counterValue <= loadValue & counterMask;
									countingDown <= 1'b1;
								end
								`TCC_AFTER_ENABLE_VALUE_SELECT_ZERO:
								begin
									counterValue <= 32'h00000000;
									countingDown <= 1'b0;
								end
								default:
									counterValue <= counterValue;
							endcase
						end
					end
					// a write racing an advance wins, the tick is lost
					`TCC_OFS_COUNTER_VALUE:    counterValue <= mergedWord & counterMask;
					`TCC_OFS_LOAD_VALUE:       loadValue <= mergedWord & counterMask;
					`TCC_OFS_CLOCK_SOURCE_SEL: clockSourceSelect <= mergedWord[1:0];
					`TCC_OFS_CLOCK_DIVIDE:     clockDivideRatio <= mergedWord[7:0];
					`TCC_OFS_PRESCALE:         prescaleCount <= mergedWord[7:0];
					`TCC_OFS_CLOCK_CONTROL:    counterClockGate <= mergedWord[0];
					default:
					begin
						if (writeHit && (ADVANCED != 0 || awAddrHeld[4:2] < 3'h4))
							captureCompareArray[writeIndex] <= mergedWord & counterMask;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;
	assign readIndex     = s_axi_araddr[4:2];

	always @*
	begin
		readWord = registerRead(s_axi_araddr);
		readHit  = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `TCC_OFS_CLOCK_CONTROL ||
			(s_axi_araddr >= `TCC_OFS_CAPTURE_BASE && s_axi_araddr <= `TCC_OFS_CAPTURE_LAST));
		if (readHit && s_axi_araddr >= `TCC_OFS_CAPTURE_BASE && ADVANCED == 0 &&
			readIndex >= 3'h4)
			readWord = `TCC_RST_WORD;
	end

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `TCC_RST_WORD;
			s_axi_rresp  <= `TCC_RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= readHit ? readWord : `TCC_RST_WORD;
			s_axi_rresp  <= readHit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// events and channel outputs
	// ----------------------------------------------------------------
	// deadband belongs to a later stage; with ADVANCED set the pair is exact inverse, else inverted stays low
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			zeroEvent            <= 1'b0;
			loadEvent            <= 1'b0;
			advanceEvent         <= 1'b0;
			timerIdle            <= 1'b1;
			truePairOutput       <= 4'h0;
			invertedPairOutput   <= 4'h0;
			internalCompareEvent <= 2'h0;
		end
		else
		begin
			advanceEvent <= advance;
			zeroEvent    <= advance && next_counterValue == 32'h00000000 &&
				counterValue != 32'h00000000;
			loadEvent    <= next_loadEvent;
			timerIdle    <= ~counterClockGate;
			for (j = 0; j < 4; j = j + 1)
			begin
				truePairOutput[j]     <= counterValue < captureCompareArray[j];
				invertedPairOutput[j] <= (ADVANCED != 0) &&
					!(counterValue < captureCompareArray[j]);
			end
			for (j = 0; j < 2; j = j + 1)
				internalCompareEvent[j] <= (ADVANCED != 0) && advance &&
					next_counterValue == captureCompareArray[j + 4];
		end
	end

endmodule

`default_nettype wire

// ===== hdl/tcc_consts.vh
// Purpose: shared constants of the timer counter clock core
// Assumes: byte addresses on an 8-bit AXI4-Lite address
// Notes:   definitions only, no logic
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TCC_OFS_COUNTER_CONTROL   8'h00
`define TCC_OFS_COUNTER_VALUE     8'h04
`define TCC_OFS_LOAD_VALUE        8'h08
`define TCC_OFS_CLOCK_SOURCE_SEL  8'h0C
`define TCC_OFS_CLOCK_DIVIDE      8'h10
`define TCC_OFS_PRESCALE          8'h14
`define TCC_OFS_CLOCK_CONTROL     8'h18
`define TCC_OFS_CAPTURE_BASE      8'h20
`define TCC_OFS_CAPTURE_LAST      8'h34

// ----------------------------------------------------------------
// counter_control field positions
// ----------------------------------------------------------------
`define TCC_CTL_ENABLE_BIT        0
`define TCC_CTL_MODE_LSB          1
`define TCC_CTL_MODE_MSB          2
`define TCC_CTL_AFTER_ENABLE_VALUE_SELECT_LSB          4
`define TCC_CTL_AFTER_ENABLE_VALUE_SELECT_MSB          5
`define TCC_CTL_REPEAT_LSB        6
`define TCC_CTL_REPEAT_MSB        7
`define TCC_CTL_ADVSRC_BIT        8

// ----------------------------------------------------------------
// field encodings
// ----------------------------------------------------------------
`define TCC_MODE_DOWN             2'h0
`define TCC_MODE_UPDOWN           2'h1
`define TCC_MODE_UP               2'h2
`define TCC_AFTER_ENABLE_VALUE_SELECT_LOAD             2'h0
`define TCC_AFTER_ENABLE_VALUE_SELECT_KEEP             2'h1
`define TCC_AFTER_ENABLE_VALUE_SELECT_ZERO             2'h2
`define TCC_SRC_BUS               2'h0
`define TCC_SRC_MID               2'h1
`define TCC_SRC_LOW               2'h2
`define TCC_RESP_OKAY             2'h0
`define TCC_RESP_SLVERR           2'h2

// ----------------------------------------------------------------
// reset values and counter masks
// ----------------------------------------------------------------
`define TCC_RST_WORD              32'h00000000
`define TCC_RST_BYTE              8'h00
`define TCC_RST_GATE              1'h0
`define TCC_MASK_NARROW           32'h0000FFFF
`define TCC_MASK_WIDE             32'hFFFFFFFF

`endif

// ===== hdl/tcc_divider.v
// Purpose: tick divider, one output pulse per (divide+1) input ticks
// Assumes: tickIn is a one-cycle pulse on clock
// Notes:   output pulse lags the input tick by one cycle
`timescale 1ns/100ps
`default_nettype none

module tcc_divider
(
	input  wire       clock,
	input  wire       arst_n,
	input  wire       run,
	input  wire       tickIn,
	input  wire [7:0] divide,
	output reg        tickOut
);

	reg [7:0] count;

	// ----------------------------------------------------------------
	// count ticks; restart from zero whenever run drops
	// ----------------------------------------------------------------
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count   <= 8'h00;
			tickOut <= 1'b0;
		end
		else if (!run)
		begin
			count   <= 8'h00;
			tickOut <= 1'b0;
		end
		else if (tickIn)
		begin
			// a lowered divide mid-count takes effect at once
			if (count >= divide)
			begin
				count   <= 8'h00;
				tickOut <= 1'b1;
			end
			else
			begin
				count   <= count + 8'h01;
				tickOut <= 1'b0;
			end
		end
		else
		begin
			tickOut <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== verification/tcc_core_asserts.sv
// Purpose: port-level checks of the timer counter core
// Assumes: bound into every tcc_core instance
// Notes:   relations between ports only, no reference model
`timescale 1ns/100ps
`default_nettype none
module tcc_core_asserts
#(
	parameter ADVANCED = 1
)
(
	input wire        clock,
	input wire        arst_n,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        zeroEvent,
	input wire        loadEvent,
	input wire        advanceEvent,
	input wire        timerIdle,
	input wire [3:0]  truePairOutput,
	input wire [3:0]  invertedPairOutput
);
// ----------------------------------------------------------------
// bus and counting relations
// ----------------------------------------------------------------
default clocking cb @(posedge clock); endclocking
default disable iff (!arst_n);
// write answer two edges after both halves are taken
a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
	s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer not on time");
a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
	else $error("second address taken");
a_w_refused: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
	else $error("second data taken");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read answer late");
a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read taken while answering");
// three idle cycles let any pulse already in the pipe drain
a_idle_quiet: assert property (timerIdle [*3] |-> !advanceEvent)
	else $error("advance while gated");
a_idle_noevent: assert property (timerIdle [*3] |-> !zeroEvent && !loadEvent)
	else $error("event while gated");
a_adv_single: assert property (advanceEvent |=> !advanceEvent)
	else $error("advance longer than one cycle");
a_pair_inverse: assert property (advanceEvent ##3 $stable(truePairOutput)
	|-> invertedPairOutput == ((ADVANCED != 0) ? ~truePairOutput : 4'h0))
	else $error("pair outputs not complementary");
c_write: cover property (s_axi_bvalid);
c_advance: cover property (advanceEvent ##1 !advanceEvent);
c_zero: cover property (zeroEvent);
endmodule
bind tcc_core tcc_core_asserts #(.ADVANCED(ADVANCED)) i_chk (.*);
`default_nettype wire

// ===== verification/timer_counter_clock_core_bench.sv
// Purpose: self-checking bench of the timer counter core
// Assumes: source clocks far slower than clock, so intervals are exact
// Notes:   one task per scenario, bus tasks shared
`timescale 1ns/100ps
`default_nettype none
module timer_counter_clock_core_bench;
logic clock, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb, truePairOutput, invertedPairOutput;
logic [1:0] s_axi_bresp, s_axi_rresp, internalCompareEvent, resp;
logic mainClockIn, ulpClockIn, midFreqClockIn, lowFreqClockIn, extAdvanceIn;
logic loadCondition, zeroCondition, zeroEvent, loadEvent, advanceEvent, timerIdle;
logic [31:0] d, e;
int bad_count, num_checks, advCount, zeroCount;
tcc_core i_dut (.*);
// ----------------------------------------------------------------
// clocks, event counters, shared tasks
// ----------------------------------------------------------------
always #2 clock = ~clock;
always #20 mainClockIn = ~mainClockIn;
always #24 midFreqClockIn = ~midFreqClockIn;
always #32 lowFreqClockIn = ~lowFreqClockIn;
always @(posedge clock)
begin
	if (advanceEvent === 1'b1) advCount <= advCount + 1;
	if (zeroEvent === 1'b1) zeroCount <= zeroCount + 1;
end
task chk(input string what, input [31:0] exp, input [31:0] got);
	num_checks++;
	if (got !== exp)
	begin
		bad_count++;
		$display("Error %s expected %h seen %h", what, exp, got);
	end
endtask
// address and data offered together, each dropped when taken
// bready and rready stay high, so back-to-back calls never drive them twice in one step
task wr(input [7:0] a, input [31:0] v);
	s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
	do
	begin
		@(posedge clock);
		if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 0;
		if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 0;
	end while (s_axi_bvalid !== 1'b1);
	resp = s_axi_bresp;
endtask
task rd(input [7:0] a);
	s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
	do
	begin
		@(posedge clock);
		if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
	end while (s_axi_rvalid !== 1'b1);
	d = s_axi_rdata; resp = s_axi_rresp;
endtask
// first two advances after a change are discarded
task interval(input [31:0] exp);
	int n;
	@(posedge clock iff advanceEvent === 1'b1);
	@(posedge clock iff advanceEvent === 1'b1);
	n = 0;
	do
	begin
		@(posedge clock); n++;
	end while (advanceEvent !== 1'b1);
	chk("advance interval", exp, n);
endtask
// ----------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------
task t_reset;
	rd(8'h00); chk("control", 32'h00000000, d);
	chk("idle", 32'h1, timerIdle);
	wr(8'h40, 32'h1); chk("unmapped write resp", 32'h2, resp);
	rd(8'h40); chk("unmapped read resp", 32'h2, resp);
	rd(8'h06); chk("unaligned resp", 32'h2, resp);
endtask
task t_rate;
	int per[3];
	per = '{10, 12, 16};
	wr(8'h08, 32'hFFFF); wr(8'h10, 0); wr(8'h14, 0); wr(8'h18, 1);
	wr(8'h00, 32'h65); chk("running", 32'h0, timerIdle);
	for (int s = 0; s < 3; s++)
	begin
		wr(8'h0C, s); interval(per[s]);
	end
	wr(8'h0C, 1); wr(8'h10, 1); wr(8'h14, 2); interval(72);
endtask
task t_gate;
	wr(8'h18, 0); repeat (8) @(posedge clock);
	rd(8'h04); e = d; repeat (100) @(posedge clock);
	rd(8'h04); chk("held counter", e, d);
	chk("idle", 32'h1, timerIdle);
	// counter written only while gated, so no advance can collide with it
	wr(8'h04, 32'hABCD1234); rd(8'h04); chk("counter", 32'h1234, d);
endtask
task t_oneshot;
	int a0, z0;
	wr(8'h00, 0); wr(8'h10, 0); wr(8'h14, 0); wr(8'h08, 3); wr(8'h18, 1);
	// counters are owned by their always block; take a snapshot instead of clearing
	a0 = advCount;
	z0 = zeroCount;
	wr(8'h00, 32'h1); repeat (150) @(posedge clock);
	chk("advances", 3, advCount - a0);
	chk("zero events", 1, zeroCount - z0);
	rd(8'h00); chk("control", 32'h0, d);
	rd(8'h04); chk("counter", 32'h0, d);
endtask
task t_hwenable;
	wr(8'h00, 0); loadCondition <= 1; @(posedge clock); loadCondition <= 0;
	repeat (2) @(posedge clock); rd(8'h00); chk("control", 32'h1, d);
	wr(8'h00, 32'h20); zeroCondition <= 1; @(posedge clock); zeroCondition <= 0;
	repeat (2) @(posedge clock); rd(8'h00); chk("control", 32'h21, d);
	wr(8'h00, 0);
endtask
// counter 5 against compare values 9 and 2: channels judged apart
task t_compare;
	wr(8'h04, 32'h5); wr(8'h20, 32'h9); wr(8'h24, 32'h2);
	repeat (2) @(posedge clock);
	chk("true outputs", 32'h1, truePairOutput);
	chk("inverted outputs", 32'hE, invertedPairOutput);
	rd(8'h24); chk("compare one", 32'h2, d);
endtask
// repeating down count 3,2,1,0,3: internal compare on 1 is two advances after reload
task t_reload;
	int n;
	wr(8'h08, 32'h3); wr(8'h30, 32'h1); wr(8'h00, 32'h41);
	@(posedge clock iff loadEvent === 1'b1);
	n = 0;
	do
	begin
		@(posedge clock);
		n++;
	end while (internalCompareEvent[0] !== 1'b1);
	chk("reload to compare", 24, n);
	wr(8'h00, 0);
endtask
// both edges of the external pin count, value kept on enable
task t_external;
	wr(8'h04, 32'h10); wr(8'h00, 32'h151);
	repeat (4)
	begin
		extAdvanceIn <= ~extAdvanceIn;
		repeat (4) @(posedge clock);
	end
	repeat (4) @(posedge clock);
	rd(8'h04); chk("external count", 32'hC, d);
	wr(8'h00, 0);
endtask
task wrap_up;
	if (bad_count == 0 && num_checks > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
// ----------------------------------------------------------------
// main sequence and watchdog
// ----------------------------------------------------------------
initial
begin
	{clock, mainClockIn, midFreqClockIn, lowFreqClockIn, ulpClockIn, extAdvanceIn} = 0;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
	{loadCondition, zeroCondition, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
	s_axi_wstrb = 4'hF; arst_n = 0; bad_count = 0; num_checks = 0;
	repeat (16) @(posedge clock);
	arst_n <= 1; @(posedge clock);
	t_reset; t_rate; t_gate; t_oneshot; t_hwenable;
	t_compare; t_reload; t_external;
	wrap_up;
end
// run needs about a thousand cycles; this is far beyond
initial
begin
	#200000 bad_count++;
	wrap_up;
end
endmodule
`default_nettype wire
